// File: include/lvd_pkg.sv
// Constants and types shared by the low-voltage detect control block
package lvd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LSEL   = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_RCAUSE = 8'h0c;

  // detect_control_reg fields
  localparam int CTRL_ON_BIT   = 7;
  localparam int CTRL_SRC_BIT  = 2;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;

  // level_select_reg field
  localparam int LSEL_W = 4;

  // Interrupt control fields
  localparam int IRQ_REQ_BIT    = 0;
  localparam int IRQ_MASK_BIT   = 1;
  localparam int IRQ_SETTLE_BIT = 2;

  // reset_cause_reg field
  localparam int RCAUSE_LVD_BIT = 0;

  // Reset values
  localparam logic              CTRL_ON_RST   = 1'b0;
  localparam logic              CTRL_SRC_RST  = 1'b0;
  localparam logic              CTRL_MODE_RST = 1'b0;
  localparam logic [LSEL_W-1:0] LSEL_RST      = 4'h0;
  localparam logic              MASK_RST      = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAB_TIME_NS  = 10000;
  localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_DELAY   = 3;

  typedef struct packed {
    logic detector_on;
    logic source_select;
    logic reset_mode_select;
  } lvd_ctrl_t;

  typedef enum logic [0:0] {
    LVD_ST_IDLE = 1'b0,
    LVD_ST_RESP = 1'b1
  } lvd_apb_st_t;

endpackage

// File: logic/lvd_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module lvd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // lvd_sync

// File: logic/lvd_ctrl.sv
// Low-voltage detect control logic with APB register access
//
// Function
// - Source select one compares the external level input.
// - Source select zero compares supply voltage; the reset default.
// - Writing detector_on one enables detection.
// - Level flag shows monitored voltage at or above threshold while enabled.
// - Reset mode set with voltage good gives no internal reset.
// - With mask clear, an interrupt may follow enabling at once.
// - Any reset sets the low-voltage interrupt mask.
// - Reset mode zero selects interrupt generation; the default.
// - Interrupt use raises interrupt on falling and rising crossings.
// - Disabling while voltage low raises an interrupt request.
// - A detector reset sets the cause flag at bit 0.
// - Level select survives detector resets, except default start ones.
`timescale 1ns/1ps
module lvd_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_ok,
  input  wire logic        external_level_input,
  input  wire logic        default_start_option,
  output logic             detector_on,
  output logic             source_select,
  output logic      [3:0]  threshold_code,
  output logic             lowv_interrupt,
  output logic             lowv_irq_pending,
  output logic             internal_reset_req
);

  lvd_pkg::lvd_ctrl_t       ctrl_ff;
  lvd_pkg::lvd_apb_st_t     st_ff;
  logic [lvd_pkg::LSEL_W-1:0] lsel_ff;
  logic       req_ff;
  logic       mask_ff;
  logic       cause_ff;
  logic       dflt_ff;
  logic       lvl_prev_ff;
  logic [1:0] strap_cnt_ff;
  logic [6:0] stab_cnt_ff;
  logic [2:0] cmp_sync;
  logic       lvl_now;
  logic       level_flag;
  logic       rise_evt;
  logic       fall_evt;
  logic       off_low_evt;
  logic       irq_evt;
  logic       lvd_rst;
  logic       settled;
  logic       acc;
  logic       wr_en;
  logic [31:0] rd_val;
  logic       rd_err;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  lvd_sync #(
    .WIDTH (3)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({default_start_option, external_level_input, supply_ok}),
    .sync_out (cmp_sync)
  );

  assign lvl_now = ctrl_ff.source_select ? cmp_sync[1] : cmp_sync[0];

  assign level_flag = ctrl_ff.detector_on & lvl_now;

  // Previous level reads high while off, so enabling into a low
  // voltage counts as a falling crossing
  assign fall_evt = ctrl_ff.detector_on & lvl_prev_ff & ~lvl_now;
  assign rise_evt = ctrl_ff.detector_on & ~lvl_prev_ff & lvl_now;

  assign off_low_evt = ~ctrl_ff.detector_on & ~lvl_prev_ff;

  assign irq_evt = ((fall_evt | rise_evt) & ~ctrl_ff.reset_mode_select) | off_low_evt;

  assign lvd_rst = ctrl_ff.detector_on & ctrl_ff.reset_mode_select & ~lvl_now;

  assign settled = (stab_cnt_ff == 7'(lvd_pkg::STAB_CYCLES));

  // APB access phase, write lands when ready is seen high
  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev_ff <= 1'b1;
    end else begin
      lvl_prev_ff <= ctrl_ff.detector_on ? lvl_now : 1'b1;
    end
  end

  // Stabilisation counter, status only; detection is not held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_ff <= 7'h00;
    end else if (!ctrl_ff.detector_on) begin
      stab_cnt_ff <= 7'h00;
    end else if (!settled) begin
      stab_cnt_ff <= stab_cnt_ff + 7'h01;
    end
  end

  // Strap sampled once, after it has crossed the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_ff <= 2'h0;
      dflt_ff      <= 1'b0;
    end else if (strap_cnt_ff != 2'(lvd_pkg::STRAP_DELAY)) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'(lvd_pkg::STRAP_DELAY - 1)) begin
        dflt_ff <= cmp_sync[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff.detector_on       <= lvd_pkg::CTRL_ON_RST;
      ctrl_ff.source_select     <= lvd_pkg::CTRL_SRC_RST;
      ctrl_ff.reset_mode_select <= lvd_pkg::CTRL_MODE_RST;
    end else if (wr_en && hit(paddr, lvd_pkg::OFS_CTRL)) begin
      ctrl_ff.detector_on       <= pwdata[lvd_pkg::CTRL_ON_BIT];
      ctrl_ff.source_select     <= pwdata[lvd_pkg::CTRL_SRC_BIT];
      ctrl_ff.reset_mode_select <= pwdata[lvd_pkg::CTRL_MODE_BIT];
    end else if (strap_cnt_ff == 2'(lvd_pkg::STRAP_DELAY - 1) && cmp_sync[2]) begin
      ctrl_ff.detector_on       <= 1'b1;
      ctrl_ff.reset_mode_select <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsel_ff <= lvd_pkg::LSEL_RST;
    end else if (lvd_rst) begin
      if (dflt_ff) begin
        lsel_ff <= lvd_pkg::LSEL_RST;
      end
    end else if (wr_en && hit(paddr, lvd_pkg::OFS_LSEL)) begin
      lsel_ff <= pwdata[lvd_pkg::LSEL_W-1:0];
    end
  end

  // Request flag: a new event beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
    end else if (irq_evt) begin
      req_ff <= 1'b1;
    end else if (wr_en && hit(paddr, lvd_pkg::OFS_IRQ) && pwdata[lvd_pkg::IRQ_REQ_BIT]) begin
      req_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= lvd_pkg::MASK_RST;
    end else if (lvd_rst) begin
      mask_ff <= 1'b1;
    end else if (wr_en && hit(paddr, lvd_pkg::OFS_IRQ)) begin
      mask_ff <= pwdata[lvd_pkg::IRQ_MASK_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= 1'b0;
    end else if (lvd_rst) begin
      cause_ff <= 1'b1;
    end else if (wr_en && hit(paddr, lvd_pkg::OFS_RCAUSE) &&
                 pwdata[lvd_pkg::RCAUSE_LVD_BIT]) begin
      cause_ff <= 1'b0;
    end
  end

  // Outputs toward analog and system
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detector_on        <= 1'b0;
      source_select      <= 1'b0;
      threshold_code     <= 4'h0;
      lowv_interrupt     <= 1'b0;
      lowv_irq_pending   <= 1'b0;
      internal_reset_req <= 1'b0;
    end else begin
      detector_on        <= ctrl_ff.detector_on;
      source_select      <= ctrl_ff.source_select;
      threshold_code     <= lsel_ff;
      lowv_interrupt     <= irq_evt;
      lowv_irq_pending   <= req_ff & ~mask_ff;
      internal_reset_req <= lvd_rst;
    end
  end

  // Read mux and decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      lvd_pkg::OFS_CTRL: begin
        rd_val[lvd_pkg::CTRL_ON_BIT]   = ctrl_ff.detector_on;
        rd_val[lvd_pkg::CTRL_SRC_BIT]  = ctrl_ff.source_select;
        rd_val[lvd_pkg::CTRL_MODE_BIT] = ctrl_ff.reset_mode_select;
        rd_val[lvd_pkg::CTRL_FLAG_BIT] = level_flag;
      end
      lvd_pkg::OFS_LSEL: begin
        rd_val[lvd_pkg::LSEL_W-1:0] = lsel_ff;
      end
      lvd_pkg::OFS_IRQ: begin
        rd_val[lvd_pkg::IRQ_REQ_BIT]    = req_ff;
        rd_val[lvd_pkg::IRQ_MASK_BIT]   = mask_ff;
        rd_val[lvd_pkg::IRQ_SETTLE_BIT] = settled;
      end
      lvd_pkg::OFS_RCAUSE: begin
        rd_val[lvd_pkg::RCAUSE_LVD_BIT] = cause_ff;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // APB slave: one wait state, ready from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff   <= lvd_pkg::LVD_ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      unique case (st_ff)
        lvd_pkg::LVD_ST_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && penable) begin
            st_ff   <= lvd_pkg::LVD_ST_RESP;
            pready  <= 1'b1;
            pslverr <= rd_err;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
          end
        end
        lvd_pkg::LVD_ST_RESP: begin
          st_ff   <= lvd_pkg::LVD_ST_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

endmodule // lvd_ctrl

// File: test/lvd_ctrl_asserts.sv
// Port checks for the low-voltage detect control block
`timescale 1ns/1ps
module lvd_ctrl_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        supply_ok,
  input wire logic        source_select,
  input wire logic        detector_on,
  input wire logic [3:0]  threshold_code,
  input wire logic        lowv_interrupt,
  input wire logic        lowv_irq_pending,
  input wire logic        internal_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  property p_on;
    s_wr(8'h00) |-> ##2 detector_on == $past(pwdata[7], 2);
  endproperty
  a_on: assert property (p_on) else $error("enable copy");
  property p_src;
    s_wr(8'h00) |-> ##2 source_select == $past(pwdata[2], 2);
  endproperty
  a_src: assert property (p_src) else $error("source copy");
  property p_thr;
    s_wr(8'h04) |-> ##2 threshold_code == $past(pwdata[3:0], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("level code copy");
  property p_rst;
    $rose(presetn) |-> !source_select && threshold_code == 4'h0 && !lowv_irq_pending;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  // Five cycles cover the sync flops and the request flop
  property p_good;
    (supply_ok && !source_select) [*5] |-> !internal_reset_req;
  endproperty
  a_good: assert property (p_good) else $error("reset with supply good");
  property p_off;
    pready && !pwrite && paddr == 8'h00 && !detector_on |-> prdata[0] == 1'h0;
  endproperty
  a_off: assert property (p_off) else $error("flag while off");
  property p_pulse;
    lowv_interrupt |=> !lowv_interrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_mask;
    internal_reset_req |-> ##1 !lowv_irq_pending;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not set");
endmodule // lvd_ctrl_asserts

bind lvd_ctrl lvd_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .supply_ok, .source_select, .detector_on, .threshold_code,
  .lowv_interrupt, .lowv_irq_pending, .internal_reset_req);

// File: test/lvd_ctrl_bench.sv
// Self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin fails++; \
  $display("unexpected %0t got %h want %h", $time, g, w); end end
module lvd_ctrl_bench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        supply_ok = 1'h1, external_level_input = 1'h1, default_start_option = 1'h0;
  logic        pready, pslverr, detector_on, source_select;
  logic        lowv_interrupt, lowv_irq_pending, internal_reset_req;
  logic [3:0]  threshold_code;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  int          fails = 0, checked = 0, pulses = 0;
  lvd_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_ok, .external_level_input, .default_start_option,
    .detector_on, .source_select, .threshold_code, .lowv_interrupt, .lowv_irq_pending,
    .internal_reset_req);
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (lowv_interrupt === 1'h1) pulses++;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Request held until pready is seen; bounded wait
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      fails++;
      print_verdict();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'h0, 32'h0);
    `CHK(prdata, e)
  endtask
  // Outputs lag the register by a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic ec(input logic s, input logic x, input int n);
    @(posedge pclk);
    supply_ok <= s;
    external_level_input <= x;
    repeat (12) @(posedge pclk);
    `CHK(pulses, n)
    pulses = 0;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h2);
    rd(8'h0c, 32'h0);
    apb(8'h10, 1'h0, 32'h0);
    `CHK(pslverr, 1'h1)
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h80);
    `CHK(detector_on, 1'h1)
    repeat (110) @(posedge pclk);
    rd(8'h00, 32'h81);
    rd(8'h08, 32'h6);
    wr(8'h08, 32'h1);
    ec(1'h0, 1'h1, 1);
    `CHK(lowv_irq_pending, 1'h1)
    rd(8'h00, 32'h80);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h4);
    ec(1'h1, 1'h1, 1);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h84);
    `CHK(source_select, 1'h1)
    ec(1'h0, 1'h1, 0);
    ec(1'h0, 1'h0, 1);
    wr(8'h00, 32'h0);
    `CHK(detector_on, 1'h0)
    ec(1'h0, 1'h0, 1);
    ec(1'h1, 1'h1, 0);
    `CHK(lowv_irq_pending, 1'h1)
    wr(8'h00, 32'h80);
    `CHK(source_select, 1'h0)
    repeat (110) @(posedge pclk);
    rd(8'h00, 32'h81);
    wr(8'h00, 32'h82);
    ec(1'h1, 1'h1, 0);
    `CHK(internal_reset_req, 1'h0)
    ec(1'h0, 1'h1, 0);
    `CHK(internal_reset_req, 1'h1)
    `CHK(lowv_irq_pending, 1'h0)
    `CHK(threshold_code, 4'h5)
    rd(8'h0c, 32'h1);
    ec(1'h1, 1'h1, 0);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    default_start_option <= 1'h1;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (10) @(posedge pclk);
    wr(8'h04, 32'h5);
    repeat (110) @(posedge pclk);
    rd(8'h00, 32'h83);
    ec(1'h0, 1'h1, 0);
    `CHK(internal_reset_req, 1'h1)
    `CHK(threshold_code, 4'h0)
    print_verdict();
  end
endmodule // lvd_ctrl_bench
